// ---- block_move_engine.sv ----
// block move engine: one instruction at a time, memory word bus and byte-wide bus link
// assumes memory answers one request at a time; bus pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "block_move_defines.svh"
module block_move_engine
  import block_move_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire move_instr_t         instr,
  input  wire logic                instr_valid,
  output logic                     instr_ready,
  input  wire logic [`ADDR_W-1:0]  data_structure_base,
  output mem_req_t                 mem_req,
  input  wire mem_rsp_t            mem_rsp,
  input  wire logic [`PHASE_W-1:0] bus_phase_in,
  input  wire logic                bus_req_in,
  input  wire logic [7:0]          bus_data_in,
  output logic [`PHASE_W-1:0]      bus_phase_out,
  output logic                     bus_phase_oe_n,
  output logic [7:0]               bus_data_out,
  output logic                     bus_data_oe_n,
  output logic                     bus_ack_out,
  output logic                     mismatch_irq,
  output logic                     fetch_next
);
  typedef enum logic [2:0] {
    S_IDLE, S_PTR_REQ, S_PTR_WAIT, S_PHASE, S_MEM_RD, S_BUS, S_MEM_WR, S_DONE
  } state_t;

  state_t                  state_reg, state_next;
  move_instr_t             ins_reg;
  logic [`COUNT_W-1:0]     count_reg;
  logic [`ADDR_W-1:0]      addr_reg;
  logic [31:0]             word_reg;
  logic [1:0]              lane_reg;
  logic [`PHASE_W-1:0]     ph_s1_reg, ph_s2_reg;
  logic                    rq_s1_reg, rq_s2_reg;
  logic [7:0]              dt_s1_reg, dt_s2_reg;
  mem_req_t                mem_req_reg;
  logic                    irq_reg, fetch_reg, ack_reg, ready_reg;

  // sign-extended table offset and start address, formed as the instruction is taken
  wire logic [`ADDR_W-1:0] ofs_ext    = {{(`ADDR_W-`COUNT_W){instr.addr[`OFS_SIGN_BIT]}},
                                         instr.addr[`COUNT_W-1:0]};
  wire logic [`ADDR_W-1:0] table_addr = data_structure_base + ofs_ext;
  wire logic [`ADDR_W-1:0] start_addr = (instr.mode == `MODE_TABLE) ? table_addr : instr.addr;
  wire logic               dir_in     = ins_reg.phase[`PH_IN_BIT];
  // level, not edge: a req raised while the pointer is fetched must not be lost
  wire logic               req_valid  = rq_s2_reg;
  wire logic               phase_ok   = (ph_s2_reg == ins_reg.phase);
  wire logic               last_lane  = (lane_reg == 2'h3) || (count_reg == 24'h000001);
  wire logic [`COUNT_W-1:0] count_dec = count_reg - 24'h000001;
  wire logic [`ADDR_W-1:0] addr_inc   = addr_reg + 32'h00000001;
  wire logic [`ADDR_W-1:0] word_addr  = {addr_reg[`ADDR_W-1:2], 2'h0};
  // a lane-3 rollover reads the word that the advanced address points into
  wire logic [`ADDR_W-1:0] rd_addr    = (state_reg == S_BUS) ? {addr_inc[`ADDR_W-1:2], 2'h0}
                                                              : word_addr;

  function automatic logic [3:0] lane_be(input logic [1:0] lane);
    lane_be = 4'h1 << lane;
  endfunction : lane_be

  // bus pins synchronised before use
  always_ff @(posedge ref_clk) begin
    ph_s1_reg <= bus_phase_in;
    ph_s2_reg <= ph_s1_reg;
    rq_s1_reg <= bus_req_in;
    rq_s2_reg <= rq_s1_reg;
    dt_s1_reg <= bus_data_in;
    dt_s2_reg <= dt_s1_reg;
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (instr_valid && ready_reg) begin
          if (instr.mode == `MODE_INDIRECT) begin
            state_next = S_PTR_REQ;
          end else begin
            state_next = S_PHASE;
          end
        end
      end
      S_PTR_REQ:  state_next = S_PTR_WAIT;
      S_PTR_WAIT: begin
        if (mem_rsp.valid) begin
          state_next = S_PHASE;
        end
      end
      S_PHASE: begin
        if (ins_reg.target_role) begin
          state_next = (count_reg == `COUNT_ZERO) ? S_DONE : (dir_in ? S_BUS : S_MEM_RD);
        end else if (req_valid) begin
          if (!phase_ok) begin
            state_next = S_DONE;
          end else begin
            state_next = (count_reg == `COUNT_ZERO) ? S_DONE : (dir_in ? S_BUS : S_MEM_RD);
          end
        end
      end
      S_MEM_RD: begin
        if (mem_rsp.valid) begin
          state_next = S_BUS;
        end
      end
      S_BUS: begin
        if (ack_reg && !rq_s2_reg) begin
          if (dir_in) begin
            state_next = S_MEM_WR;
          end else if (count_reg == 24'h000001) begin
            state_next = S_DONE;
          end else if (last_lane) begin
            state_next = S_MEM_RD;
          end
        end
      end
      S_MEM_WR: begin
        if (mem_rsp.valid) begin
          state_next = (count_reg == `COUNT_ZERO) ? S_DONE : S_BUS;
        end
      end
      S_DONE:  state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // instruction latch, count and address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ins_reg   <= '0;
      count_reg <= `COUNT_ZERO;
      addr_reg  <= 32'h00000000;
      lane_reg  <= 2'h0;
    end else if (state_reg == S_IDLE && instr_valid && ready_reg) begin
      ins_reg   <= instr;
      count_reg <= instr.count;
      addr_reg  <= start_addr;
      lane_reg  <= start_addr[1:0];
    end else if (state_reg == S_PTR_WAIT && mem_rsp.valid) begin
      addr_reg  <= mem_rsp.rdata;
      lane_reg  <= mem_rsp.rdata[1:0];
    end else if (state_reg == S_BUS && ack_reg && !rq_s2_reg) begin
      count_reg <= count_dec;
      addr_reg  <= addr_inc;
      lane_reg  <= addr_inc[1:0];
    end
  end

  // byte shuttle between memory word and bus
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_reg <= 32'h00000000;
    end else if (state_reg == S_MEM_RD && mem_rsp.valid) begin
      word_reg <= mem_rsp.rdata;
    end else if (state_reg == S_BUS && dir_in && rq_s2_reg && !ack_reg) begin
      word_reg[lane_reg*8 +: 8] <= dt_s2_reg;
    end
  end

  // bus handshake: ack follows req; as target, ack also pulses on its own while req is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else if (state_reg == S_BUS) begin
      ack_reg <= rq_s2_reg | ins_reg.target_role & ~ack_reg & ~rq_s2_reg;
    end else begin
      ack_reg <= 1'b0;
    end
  end

  // memory requests
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_req_reg <= '0;
    end else if (mem_rsp.valid) begin
      mem_req_reg <= '0;
    end else if (state_reg == S_PTR_REQ) begin
      mem_req_reg <= '{valid: 1'b1, write: 1'b0, addr: ins_reg.addr, wdata: 32'h00000000, be: 4'hF};
    end else if (state_next == S_MEM_RD && state_reg != S_MEM_RD) begin
      mem_req_reg <= '{valid: 1'b1, write: 1'b0, addr: rd_addr, wdata: 32'h00000000, be: 4'hF};
    end else if (state_next == S_MEM_WR && state_reg != S_MEM_WR) begin
      mem_req_reg <= '{valid: 1'b1, write: 1'b1, addr: word_addr, wdata: word_reg,
                       be: lane_be(lane_reg)};
    end
  end

  // events, phase drive and ready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_reg        <= 1'b0;
      fetch_reg      <= 1'b0;
      ready_reg      <= 1'b0;
      bus_phase_out  <= `PH_DATA_OUT;
      bus_phase_oe_n <= 1'b1;
      bus_data_out   <= 8'h00;
      bus_data_oe_n  <= 1'b1;
    end else begin
      irq_reg        <= (state_reg == S_PHASE) && !ins_reg.target_role && req_valid && !phase_ok;
      fetch_reg      <= (state_next == S_DONE) && !(state_reg == S_PHASE && !ins_reg.target_role
                        && !phase_ok);
      ready_reg      <= (state_next == S_IDLE) && !(instr_valid && ready_reg);
      bus_phase_out  <= ins_reg.phase;
      bus_phase_oe_n <= !(ins_reg.target_role && state_reg != S_IDLE && state_reg != S_DONE);
      bus_data_out   <= word_reg[lane_reg*8 +: 8];
      bus_data_oe_n  <= !(state_reg == S_BUS && !dir_in);
    end
  end

  assign instr_ready  = ready_reg;
  assign mem_req      = mem_req_reg;
  assign bus_ack_out  = ack_reg;
  assign mismatch_irq = irq_reg;
  assign fetch_next   = fetch_reg;

  mismatch_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    irq_reg |-> !fetch_reg && $past(state_reg) == S_PHASE)
    else $error("mismatch irq without phase check");
  no_move_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_PHASE && !ins_reg.target_role && req_valid && !phase_ok) |=> state_reg == S_DONE)
    else $error("data moved after mismatch");
  count_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_BUS && ack_reg && !rq_s2_reg) |=> count_reg == $past(count_reg) - 24'h000001)
    else $error("count not decremented");
  table_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_IDLE && instr_valid && ready_reg && instr.mode == `MODE_TABLE)
    |=> addr_reg == $past(table_addr))
    else $error("table address wrong");
  ptr_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_PTR_WAIT && mem_rsp.valid) |=> addr_reg == $past(mem_rsp.rdata))
    else $error("pointer not loaded");
  target_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_BUS && ins_reg.target_role) |-> !bus_phase_oe_n)
    else $error("target not driving phase");
  init_no_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg != S_IDLE && !ins_reg.target_role) |=> bus_phase_oe_n)
    else $error("initiator driving phase");
  done_fetch_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == S_BUS && ack_reg && !rq_s2_reg && count_reg == 24'h000001 && !dir_in)
    |=> ##[0:1] fetch_reg)
    else $error("no fetch at count zero");
  cv_mismatch: cover property (@(posedge ref_clk) irq_reg);
  cv_fetch: cover property (@(posedge ref_clk) fetch_reg);
  cv_indirect: cover property (@(posedge ref_clk) state_reg == S_PTR_WAIT && mem_rsp.valid);
  cv_write: cover property (@(posedge ref_clk) mem_req_reg.valid && mem_req_reg.write);
  cv_target: cover property (@(posedge ref_clk) state_reg == S_BUS && ins_reg.target_role);
endmodule : block_move_engine
`default_nettype wire

// ---- block_move_defines.svh ----
// constants for the block move engine: addressing modes, phases, field layouts
// assumes a single 200 MHz clock domain and a synchronous active-high reset
// Overview of operation
// - a block move carries data between memory and the bus, direction taken from the phase.
// - as initiator the engine waits for a valid bus phase; as target it drives the phase lines.
// - as initiator the instruction phase is compared with the bus phase before any data moves.
// - on an initiator phase mismatch an interrupt is raised and no data is moved.
// - on a phase match data goes in or out of memory as the phase lines say.
// - when the remaining count reaches zero the next sequential instruction is fetched.
// - the byte count is a 24-bit unsigned number of bytes.
// - in direct mode the instruction holds the full 32-bit buffer address.
// - a function code selects the target role (sets phase) or initiator role (tests phase).
// - the phase field names one of eight phases, two of them reserved.
// - block moves and chained block moves support direct, indirect and table indirect modes.
// - in indirect mode the address points at a word holding the real buffer address.
// - in table indirect mode a signed 24-bit offset is added to the data structure base.
`ifndef BLOCK_MOVE_DEFINES_SVH
`define BLOCK_MOVE_DEFINES_SVH
`define COUNT_W        24
`define ADDR_W         32
`define PHASE_W        3
`define MODE_W         2
`define MODE_DIRECT    2'h0
`define MODE_INDIRECT  2'h1
`define MODE_TABLE     2'h2
`define PH_DATA_OUT    3'h0
`define PH_DATA_IN     3'h1
`define PH_CMD         3'h2
`define PH_STATUS      3'h3
`define PH_RES_A       3'h4
`define PH_RES_B       3'h5
`define PH_MSG_OUT     3'h6
`define PH_MSG_IN      3'h7
`define PH_IN_BIT      0
`define OFS_SIGN_BIT   23
`define BYTES_PER_BEAT 3'h4
`define COUNT_ZERO     24'h000000
`endif

// ---- block_move_pkg.sv ----
// types for the block move engine
// assumes block_move_defines.svh is on the include path
`include "block_move_defines.svh"
package block_move_pkg;
  typedef struct packed {
    logic                   chained;
    logic                   target_role;
    logic [`MODE_W-1:0]     mode;
    logic [`PHASE_W-1:0]    phase;
    logic [`COUNT_W-1:0]    count;
    logic [`ADDR_W-1:0]     addr;
  } move_instr_t;
  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [`ADDR_W-1:0]     addr;
    logic [31:0]            wdata;
    logic [3:0]             be;
  } mem_req_t;
  typedef struct packed {
    logic                   valid;
    logic [31:0]            rdata;
  } mem_rsp_t;
endpackage : block_move_pkg

// ---- block_move_peer.sv ----
// partner: bus target peer and word memory
// assumes its tasks are called 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none
module block_move_peer
  import block_move_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire mem_req_t   mem_req,
  output var  mem_rsp_t   mem_rsp,
  input  wire logic       bus_ack_out,
  input  wire logic [7:0] bus_data_out,
  input  wire logic       bus_data_oe_n,
  output logic [2:0]      bus_phase_in,
  output logic            bus_req_in,
  output logic [7:0]      bus_data_in
);
  logic [31:0] mem [16];
  int          lat = 0;
  int          cnt = 0;
  int          tmo = 0;
  initial begin
    mem_rsp = '0;
    bus_phase_in = 3'h0;
    bus_req_in = 1'b0;
    bus_data_in = 8'h5A;
  end
  // one request at a time, answered after lat cycles
  always @(posedge ref_clk) begin
    mem_rsp.valid <= 1'b0;
    mem_rsp.rdata <= ~mem_rsp.rdata;
    if (mem_req.valid && !mem_rsp.valid) begin
      cnt <= (cnt >= lat) ? 0 : cnt + 1;
      if (cnt >= lat) begin
        mem_rsp.valid <= 1'b1;
        mem_rsp.rdata <= mem[mem_req.addr[5:2]];
        for (int b = 0; b < 4; b++)
          if (mem_req.write && mem_req.be[b])
            mem[mem_req.addr[5:2]][8*b+:8] <= mem_req.wdata[8*b+:8];
      end
    end
  end
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (bus_ack_out !== lvl && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 400) tmo++;
  endtask : wait_ack
  // data held until ack falls, then inverted
  task automatic send_byte(input logic [7:0] d);
    bus_data_in = d;
    bus_req_in = 1'b1;
    wait_ack(1'b1);
    bus_req_in = 1'b0;
    wait_ack(1'b0);
    bus_data_in = ~d;
    @(posedge ref_clk);
    #1;
  endtask : send_byte
  task automatic get_byte(output logic [7:0] d, output logic oe_n);
    bus_req_in = 1'b1;
    wait_ack(1'b1);
    d = bus_data_out;
    oe_n = bus_data_oe_n;
    bus_req_in = 1'b0;
    wait_ack(1'b0);
  endtask : get_byte
endmodule : block_move_peer
`default_nettype wire

// ---- scsi_block_move_engine_test.sv ----
// testbench: block move scenarios against the peer model
// assumes design files and block_move_peer compiled first
`timescale 1ns/1ps
`default_nettype none
`include "block_move_defines.svh"
module scsi_block_move_engine_test
  import block_move_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  move_instr_t instr;
  logic        instr_valid;
  logic [31:0] dsb;
  logic        chain;
  logic [7:0]  out_seen;
  logic        instr_ready, bus_req_in, bus_ack_out, bus_phase_oe_n;
  logic        bus_data_oe_n, mismatch_irq, fetch_next, seen;
  logic [2:0]  bus_phase_in, bus_phase_out;
  logic [7:0]  bus_data_in, bus_data_out;
  mem_req_t    mem_req;
  mem_rsp_t    mem_rsp;
  int          errors = 0, num_checks = 0, fn_cnt = 0, irq_cnt = 0, fn0, irq0;
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  block_move_engine uut (.ref_clk, .rst, .instr, .instr_valid, .instr_ready,
    .data_structure_base(dsb), .mem_req, .mem_rsp, .bus_phase_in, .bus_req_in,
    .bus_data_in, .bus_phase_out, .bus_phase_oe_n, .bus_data_out, .bus_data_oe_n,
    .bus_ack_out, .mismatch_irq, .fetch_next);
  block_move_peer peer (.ref_clk, .mem_req, .mem_rsp, .bus_ack_out, .bus_data_out,
    .bus_data_oe_n, .bus_phase_in, .bus_req_in, .bus_data_in);
  always @(posedge ref_clk) begin
    if (fetch_next === 1'b1) fn_cnt++;
    if (mismatch_irq === 1'b1) irq_cnt++;
    if (bus_phase_oe_n === 1'b0 && bus_phase_out === instr.phase) seen = 1'b1;
    if (bus_ack_out === 1'b1 && bus_data_oe_n === 1'b0) out_seen = bus_data_out;
  end
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic report_and_stop();
    errors += peer.tmo;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic issue(input logic tr, input logic [1:0] md, input logic [2:0] ph,
                       input logic [23:0] cnt, input logic [31:0] ad);
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (instr_ready !== 1'b1) begin
      errors++;
      report_and_stop();
    end
    fn0 = fn_cnt;
    irq0 = irq_cnt;
    seen = 1'b0;
    out_seen = 8'h00;
    instr = {chain, tr, md, ph, cnt, ad};
    instr_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
  endtask : issue
  task automatic wait_ev(input logic [31:0] fn, input logic [31:0] irq);
    int n;
    n = 0;
    while (fn_cnt + irq_cnt == fn0 + irq0) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 3000) begin
        errors++;
        report_and_stop();
      end
    end
    check("fetch_next", fn, fn_cnt - fn0);
    check("mismatch_irq", irq, irq_cnt - irq0);
  endtask : wait_ev
  task automatic t_reset();
    repeat (10) @(posedge ref_clk);
    #1;
    check("phase_oe_n", 1, bus_phase_oe_n);
    check("data_oe_n", 1, bus_data_oe_n);
    check("ready_in_rst", 0, instr_ready);
    rst = 1'b0;
    $display("test reset done");
  endtask : t_reset
  task automatic t_in();
    peer.lat = 2;
    peer.mem[4] = '0;
    peer.mem[5] = '0;
    peer.bus_phase_in = `PH_DATA_IN;
    issue(1'b0, `MODE_DIRECT, `PH_DATA_IN, 24'h000004, 32'h00000011);
    peer.send_byte(8'hA1);
    peer.send_byte(8'hB2);
    peer.send_byte(8'hC3);
    peer.send_byte(8'hD4);
    wait_ev(1, 0);
    check("word4", 32'hC3B2A100, peer.mem[4]);
    check("word5", 32'h000000D4, peer.mem[5]);
    $display("test data in done");
  endtask : t_in
  task automatic t_out();
    logic [7:0] d;
    logic       oe;
    logic [7:0] e [3] = '{8'h33, 8'h44, 8'h55};
    peer.lat = 0;
    peer.mem[7] = 32'h44332211;
    peer.mem[8] = 32'h88776655;
    peer.bus_phase_in = `PH_DATA_OUT;
    issue(1'b0, `MODE_DIRECT, `PH_DATA_OUT, 24'h000003, 32'h0000001E);
    for (int i = 0; i < 3; i++) begin
      peer.get_byte(d, oe);
      check("out_byte", e[i], d);
      check("out_oe_n", 0, oe);
    end
    wait_ev(1, 0);
    $display("test data out done");
  endtask : t_out
  task automatic t_zero_and_mismatch();
    peer.mem[0] = 32'h5A5A5A5A;
    for (int p = 0; p < 9; p++) begin
      peer.bus_phase_in = (p == 8) ? `PH_STATUS : 3'(p ^ 1);
      issue(1'b0, `MODE_DIRECT, (p == 8) ? `PH_STATUS : 3'(p), (p == 8) ? 24'h000000 : 24'h000004, 0);
      peer.bus_req_in = 1'b1;
      wait_ev((p == 8) ? 1 : 0, (p == 8) ? 0 : 1);
      peer.bus_req_in = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
    end
    check("untouched", 32'h5A5A5A5A, peer.mem[0]);
    $display("test phase compare done");
  endtask : t_zero_and_mismatch
  task automatic t_modes();
    peer.lat = 1;
    peer.mem[0] = 32'h00000020;
    peer.mem[8] = '0;
    peer.mem[12] = '0;
    peer.bus_phase_in = `PH_DATA_IN;
    chain = 1'b1;
    issue(1'b0, `MODE_INDIRECT, `PH_DATA_IN, 24'h000002, 32'h00000000);
    chain = 1'b0;
    peer.send_byte(8'hE1);
    peer.send_byte(8'hE2);
    wait_ev(1, 0);
    check("indirect", 32'h0000E2E1, peer.mem[8]);
    dsb = 32'h00000040;
    issue(1'b0, `MODE_TABLE, `PH_DATA_IN, 24'h000001, 32'hAAFFFFF0);
    peer.send_byte(8'hF7);
    wait_ev(1, 0);
    check("table", 32'h000000F7, peer.mem[12]);
    $display("test modes done");
  endtask : t_modes
  task automatic t_target();
    peer.bus_phase_in = `PH_DATA_OUT;
    issue(1'b1, `MODE_DIRECT, `PH_CMD, 24'h000000, 0);
    wait_ev(1, 0);
    check("phase_drive", 1, seen);
    peer.mem[7] = 32'h44332211;
    issue(1'b1, `MODE_DIRECT, `PH_DATA_OUT, 24'h000001, 32'h0000001D);
    wait_ev(1, 0);
    check("target_byte", 8'h22, out_seen);
    check("target_drive", 1, seen);
    $display("test target done");
  endtask : t_target
  initial begin
    rst = 1'b1;
    instr = '0;
    instr_valid = 1'b0;
    dsb = 32'h00000000;
    chain = 1'b0;
    out_seen = 8'h00;
    t_reset();
    t_in();
    t_out();
    t_zero_and_mismatch();
    t_modes();
    t_target();
    report_and_stop();
  end
endmodule : scsi_block_move_engine_test
`default_nettype wire
